// >>> hw/force_limit_selector.sv
// force limit selector: APB settings, terminal routing, limit selection
// assumes terminal inputs come from pins (synchronised here), signed analog reference
// arrives already digitised on pclk as percent of rated force
`default_nettype none
module force_limit_selector (
    input  wire logic                          pclk,        // control clock 100 MHz
    input  wire logic                          presetn,     // async reset, active low
    input  wire flim_pkg::apb_req_t            apb_req,     // apb request group
    output logic [31:0]                        prdata,      // apb read data
    output logic                               pready,      // apb ready
    output logic                               pslverr,     // apb error
    input  wire logic [flim_pkg::TERM_N-1:0]   term_in,     // input terminals, 1 = closed
    input  wire logic signed [flim_pkg::AREF_W-1:0] analog_ref, // analog limit, signed percent
    input  wire flim_pkg::ctrl_mode_t          ctrl_mode,   // active control method
    output flim_pkg::limit_pair_t              limit_out,   // effective limits
    output logic                               analog_mode  // analog limiting in use
);
    import flim_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic [LIM_W-1:0] fwd_internal_limit_q, fwd_internal_limit_d;
    logic [LIM_W-1:0] rev_internal_limit_q, rev_internal_limit_d;
    logic [LIM_W-1:0] fwd_external_limit_q, fwd_external_limit_d;
    logic [LIM_W-1:0] rev_external_limit_q, rev_external_limit_d;
    logic [LIM_W-1:0] motor_max_q,          motor_max_d;
    logic [3:0]       function_select_q,    function_select_d;
    logic [3:0]       fsel_active_q;
    logic [7:0]       input_alloc_setting_q, input_alloc_setting_d;
    logic [31:0]      prdata_q, prdata_d;
    logic             pready_q, pready_d;
    logic             pslverr_q, pslverr_d;
    logic             arm_q;
    logic [TERM_N-1:0] term_s1_q, term_s2_q;
    logic             fwd_ext_limit_in, rev_ext_limit_in;
    limit_pair_t      limit_q, limit_d;
    logic             amode_q, amode_d;

    // settings above 800 are clipped to the documented range
    function automatic logic [LIM_W-1:0] clip_set(input logic [31:0] v);
        clip_set = (v > 32'(LIM_MAX_SET)) ? LIM_MAX_SET : v[LIM_W-1:0];
    endfunction

    function automatic logic [LIM_W-1:0] min2(input logic [LIM_W-1:0] a, input logic [LIM_W-1:0] b);
        min2 = (a < b) ? a : b;
    endfunction

    // ****************************************
    // apb slave, zero wait states
    // ****************************************
    logic wr_en, rd_en;
    // a write lands at the edge where the master samples pready high, never earlier
    assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && pready_q;
    assign rd_en = apb_req.psel && !apb_req.penable;

    always_comb begin
        fwd_internal_limit_d  = fwd_internal_limit_q;
        rev_internal_limit_d  = rev_internal_limit_q;
        fwd_external_limit_d  = fwd_external_limit_q;
        rev_external_limit_d  = rev_external_limit_q;
        motor_max_d           = motor_max_q;
        function_select_d     = function_select_q;
        input_alloc_setting_d = input_alloc_setting_q;
        prdata_d              = prdata_q;
        pready_d              = apb_req.psel && !apb_req.penable;
        pslverr_d             = 1'b0;
        if (wr_en) begin
            unique case (apb_req.paddr)
                OFS_FWD_INT:   fwd_internal_limit_d  = clip_set(apb_req.pwdata);
                OFS_REV_INT:   rev_internal_limit_d  = clip_set(apb_req.pwdata);
                OFS_FWD_EXT:   fwd_external_limit_d  = clip_set(apb_req.pwdata);
                OFS_REV_EXT:   rev_external_limit_d  = clip_set(apb_req.pwdata);
                OFS_FSEL:      function_select_d     = apb_req.pwdata[3:0];
                OFS_ALLOC:     input_alloc_setting_d = apb_req.pwdata[7:0];
                OFS_MOTOR_MAX: motor_max_d           = clip_set(apb_req.pwdata);
                default: ;
            endcase
        end
        if (rd_en) begin
            unique case (apb_req.paddr)
                OFS_FWD_INT:   prdata_d = {22'h0, fwd_internal_limit_q};
                OFS_REV_INT:   prdata_d = {22'h0, rev_internal_limit_q};
                OFS_FWD_EXT:   prdata_d = {22'h0, fwd_external_limit_q};
                OFS_REV_EXT:   prdata_d = {22'h0, rev_external_limit_q};
                OFS_FSEL:      prdata_d = {24'h0, fsel_active_q, function_select_q};
                OFS_ALLOC:     prdata_d = {24'h0, input_alloc_setting_q};
                OFS_MOTOR_MAX: prdata_d = {22'h0, motor_max_q};
                OFS_STATUS:    prdata_d = {9'h0, amode_q, rev_ext_limit_in, fwd_ext_limit_in,
                                           limit_q.rev, limit_q.fwd};
                default:       prdata_d = 32'h0;
            endcase
        end
        if (apb_req.psel && !apb_req.penable) begin
            pslverr_d = (apb_req.paddr > OFS_STATUS) || (apb_req.paddr[1:0] != 2'h0) ||
                        (apb_req.pwrite && apb_req.paddr == OFS_STATUS);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_internal_limit_q  <= INT_RST;
            rev_internal_limit_q  <= INT_RST;
            fwd_external_limit_q  <= EXT_RST;
            rev_external_limit_q  <= EXT_RST;
            motor_max_q           <= MOTOR_MAX_RST;
            input_alloc_setting_q <= {1'b0, REV_TERM_RST, 1'b0, FWD_TERM_RST};
            prdata_q              <= 32'h0;
            pready_q              <= 1'b0;
            pslverr_q             <= 1'b0;
        end else begin
            fwd_internal_limit_q  <= fwd_internal_limit_d;
            rev_internal_limit_q  <= rev_internal_limit_d;
            fwd_external_limit_q  <= fwd_external_limit_d;
            rev_external_limit_q  <= rev_external_limit_d;
            motor_max_q           <= motor_max_d;
            input_alloc_setting_q <= input_alloc_setting_d;
            prdata_q              <= prdata_d;
            pready_q              <= pready_d;
            pslverr_q             <= pslverr_d;
        end
    end

    // ****************************************
    // restart capture of function select
    // ****************************************
    // the stored setting survives a reset, otherwise a restart would always wipe the new mode
    always_ff @(posedge pclk) begin
        function_select_q <= function_select_d;
    end

    // the mode is latched once after reset release; later writes wait for a restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_q         <= 1'b1;
            fsel_active_q <= 4'h0;
        end else if (arm_q) begin
            arm_q         <= 1'b0;
            // only the analog code matters; a never-written setting starts inactive
            if (function_select_q == FSEL_ANALOG) begin
                fsel_active_q <= FSEL_ANALOG;
            end else begin
                fsel_active_q <= 4'h0;
            end
        end
    end

    // ****************************************
    // terminal synchronisers and routing
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_s1_q <= '0;
            term_s2_q <= '0;
        end else begin
            term_s1_q <= term_in;
            term_s2_q <= term_s1_q;
        end
    end

    assign fwd_ext_limit_in = term_s2_q[input_alloc_setting_q[ALLOC_FWD_LSB +: TERM_W]];
    assign rev_ext_limit_in = term_s2_q[input_alloc_setting_q[ALLOC_REV_LSB +: TERM_W]];

    // ****************************************
    // limit selection
    // ****************************************
    logic [AREF_W-1:0] amag;
    logic [LIM_W-1:0]  alim;
    logic [LIM_W-1:0]  fsel, rsel;
    always_comb begin
        amag    = analog_ref[AREF_W-1] ? AREF_W'(-analog_ref) : analog_ref;
        alim    = (amag > AREF_W'(LIM_MAX_SET)) ? LIM_MAX_SET : amag[LIM_W-1:0];
        amode_d = (fsel_active_q == FSEL_ANALOG) && (ctrl_mode != CTRL_FORCE);
        fsel    = fwd_internal_limit_q;
        rsel    = rev_internal_limit_q;
        if (fwd_ext_limit_in) begin
            fsel = min2(fsel, fwd_external_limit_q);
        end
        if (rev_ext_limit_in) begin
            rsel = min2(rsel, rev_external_limit_q);
        end
        if (amode_d) begin
            fsel = min2(fsel, alim);
            rsel = min2(rsel, alim);
        end
        limit_d.fwd = min2(fsel, motor_max_q);
        limit_d.rev = min2(rsel, motor_max_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_q <= '0;
            amode_q <= 1'b0;
        end else begin
            limit_q <= limit_d;
            amode_q <= amode_d;
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign limit_out   = limit_q;
    assign analog_mode = amode_q;

    // ****************************************
    // assertions
    // ****************************************
    property p_fwd_cap;
        @(posedge pclk) disable iff (!presetn) limit_out.fwd <= $past(fwd_internal_limit_q);
    endproperty
    a_fwd_cap: assert property (p_fwd_cap) else $error("forward limit above internal");

    property p_rev_cap;
        @(posedge pclk) disable iff (!presetn) limit_out.rev <= $past(rev_internal_limit_q);
    endproperty
    a_rev_cap: assert property (p_rev_cap) else $error("reverse limit above internal");

    property p_range;
        @(posedge pclk) disable iff (!presetn)
            fwd_internal_limit_q <= LIM_MAX_SET && rev_external_limit_q <= LIM_MAX_SET;
    endproperty
    a_range: assert property (p_range) else $error("setting out of range");

    property p_motor_max;
        @(posedge pclk) disable iff (!presetn)
            limit_out.fwd <= $past(motor_max_q) && limit_out.rev <= $past(motor_max_q);
    endproperty
    a_motor_max: assert property (p_motor_max) else $error("limit above motor maximum");

    property p_fwd_ext;
        @(posedge pclk) disable iff (!presetn)
            fwd_ext_limit_in && !amode_d |=> limit_out.fwd ==
                min2(min2($past(fwd_internal_limit_q), $past(fwd_external_limit_q)), $past(motor_max_q));
    endproperty
    a_fwd_ext: assert property (p_fwd_ext) else $error("forward external limit wrong");

    property p_fwd_off;
        @(posedge pclk) disable iff (!presetn)
            !fwd_ext_limit_in && !amode_d |=> limit_out.fwd ==
                min2($past(fwd_internal_limit_q), $past(motor_max_q));
    endproperty
    a_fwd_off: assert property (p_fwd_off) else $error("forward internal only wrong");

    property p_rev_ext;
        @(posedge pclk) disable iff (!presetn)
            rev_ext_limit_in && !amode_d |=> limit_out.rev ==
                min2(min2($past(rev_internal_limit_q), $past(rev_external_limit_q)), $past(motor_max_q));
    endproperty
    a_rev_ext: assert property (p_rev_ext) else $error("reverse external limit wrong");

    property p_fsel_hold;
        @(posedge pclk) disable iff (!presetn) !arm_q && !$past(arm_q) |-> $stable(fsel_active_q);
    endproperty
    a_fsel_hold: assert property (p_fsel_hold) else $error("function select changed without restart");

    property p_force_mode;
        @(posedge pclk) disable iff (!presetn) ctrl_mode == CTRL_FORCE |=> !analog_mode;
    endproperty
    a_force_mode: assert property (p_force_mode) else $error("analog limit in force control");

    property p_rev_off;
        @(posedge pclk) disable iff (!presetn)
            !rev_ext_limit_in && !amode_d |=> limit_out.rev ==
                min2($past(rev_internal_limit_q), $past(motor_max_q));
    endproperty
    a_rev_off: assert property (p_rev_off) else $error("reverse internal only wrong");

    property p_analog;
        @(posedge pclk) disable iff (!presetn)
            amode_d |=> limit_out.fwd <= $past(alim) && limit_out.rev <= $past(alim);
    endproperty
    a_analog: assert property (p_analog) else $error("limit above analog limit");

    property p_analog_sym;
        @(posedge pclk) disable iff (!presetn)
            amode_d && !fwd_ext_limit_in && !rev_ext_limit_in && fwd_internal_limit_q == rev_internal_limit_q
                |=> limit_out.fwd == limit_out.rev;
    endproperty
    a_analog_sym: assert property (p_analog_sym) else $error("analog limit differs by direction");

    property p_write_now;
        @(posedge pclk) disable iff (!presetn)
            wr_en && apb_req.paddr == OFS_FWD_INT |=> fwd_internal_limit_q == clip_set($past(apb_req.pwdata));
    endproperty
    a_write_now: assert property (p_write_now) else $error("setting write not applied at once");

    property p_range_all;
        @(posedge pclk) disable iff (!presetn)
            rev_internal_limit_q <= LIM_MAX_SET && fwd_external_limit_q <= LIM_MAX_SET &&
                motor_max_q <= LIM_MAX_SET;
    endproperty
    a_range_all: assert property (p_range_all) else $error("setting out of range");

    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn) pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held longer than one cycle");

    property p_err_ready;
        @(posedge pclk) disable iff (!presetn) pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error flag without ready");
endmodule
`default_nettype wire

// >>> hw/flim_pkg.sv
// constants and carrier types for the force limit selector
// assumes a single control clock pclk and APB access to the settings
`default_nettype none
package flim_pkg;
    localparam int unsigned LIM_W       = 10;
    localparam int unsigned TERM_N      = 8;
    localparam int unsigned TERM_W      = 3;
    localparam int unsigned AREF_W      = 16;
    localparam logic [9:0]  LIM_MAX_SET = 10'h320;
    localparam logic [9:0]  INT_RST     = 10'h01e;
    localparam logic [9:0]  EXT_RST     = 10'h064;
    localparam logic [9:0]  MOTOR_MAX_RST = 10'h12c;
    localparam logic [3:0]  FSEL_ANALOG = 4'h1;
    localparam logic [2:0]  FWD_TERM_RST = 3'h0;
    localparam logic [2:0]  REV_TERM_RST = 3'h1;
    // byte offsets
    localparam logic [7:0]  OFS_FWD_INT   = 8'h00;
    localparam logic [7:0]  OFS_REV_INT   = 8'h04;
    localparam logic [7:0]  OFS_FWD_EXT   = 8'h08;
    localparam logic [7:0]  OFS_REV_EXT   = 8'h0c;
    localparam logic [7:0]  OFS_FSEL      = 8'h10;
    localparam logic [7:0]  OFS_ALLOC     = 8'h14;
    localparam logic [7:0]  OFS_MOTOR_MAX = 8'h18;
    localparam logic [7:0]  OFS_STATUS    = 8'h1c;
    localparam int unsigned ALLOC_FWD_LSB = 0;
    localparam int unsigned ALLOC_REV_LSB = 4;

    typedef enum logic [1:0] {
        CTRL_SPEED    = 2'b00,
        CTRL_POSITION = 2'b01,
        CTRL_FORCE    = 2'b10
    } ctrl_mode_t;

    typedef struct packed {
        logic [LIM_W-1:0] fwd;
        logic [LIM_W-1:0] rev;
    } limit_pair_t;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage
`default_nettype wire

// >>> verif/host_limit_model.sv
// host controller model: closes the external limit contacts on chosen terminals
// assumes the bench sets the requests right after a rising pclk edge
`default_nettype none
module host_limit_model (
    input  wire logic       fwd_on,   // forward reduced force wanted
    input  wire logic       rev_on,   // reverse reduced force wanted
    input  wire logic [2:0] fwd_term, // terminal wired to forward input
    input  wire logic [2:0] rev_term, // terminal wired to reverse input
    output logic [7:0]      term_out  // contacts, 1 = closed
);
    timeunit 1ns;
    timeprecision 1ps;
    // open contacts read as 0, so a released input never shows a stale level
    always_comb begin
        term_out = 8'h00;
        if (fwd_on) begin
            term_out[fwd_term] = 1'b1;
        end
        if (rev_on) begin
            term_out[rev_term] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> verif/force_limit_selector_tb_top.sv
// self-checking bench for the force limit selector
// assumes a 3-edge terminal-to-limit latency; apb transfers wait for pready
`default_nettype none
module force_limit_selector_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import flim_pkg::*;
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    apb_req_t           apb_req = '0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [7:0]         term_in;
    logic signed [15:0] analog_ref = 16'h0000;
    ctrl_mode_t         ctrl_mode = CTRL_SPEED;
    limit_pair_t        limit_out;
    logic               analog_mode;
    logic               fwd_on = 1'b0;
    logic               rev_on = 1'b0;
    logic [2:0]         fwd_term = 3'h0;
    logic [2:0]         rev_term = 3'h1;
    logic [31:0]        rd;
    logic               er;
    int                 bad_count = 0;
    int                 n_tests = 0;
    int                 cyc = 0;

    force_limit_selector u_force_limit_selector (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .term_in(term_in), .analog_ref(analog_ref),
        .ctrl_mode(ctrl_mode), .limit_out(limit_out), .analog_mode(analog_mode));
    host_limit_model u_host_limit_model (.fwd_on(fwd_on), .rev_on(rev_on), .fwd_term(fwd_term),
        .rev_term(rev_term), .term_out(term_in));

    always #5 pclk = ~pclk;

    // ****************
    // helpers
    // ****************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic lim(input logic [9:0] f, input logic [9:0] r);
        chk({22'h0, limit_out.fwd}, {22'h0, f});
        chk({22'h0, limit_out.rev}, {22'h0, r});
    endtask
    // outputs are read at the edge, before that edge's own updates land
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        apb_req <= '0;
    endtask
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_defaults();
        lim(10'h01e, 10'h01e);
        apb(1'b0, OFS_REV_INT, 32'h0);
        chk(rd, 32'h0000001e);
        chk({31'h0, er}, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, OFS_STATUS, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("defaults done");
    endtask
    task automatic t_internal();
        apb(1'b1, OFS_FWD_INT, 32'h1f4);
        apb(1'b1, OFS_REV_INT, 32'h0);
        settle(2);
        lim(10'h12c, 10'h000);
        apb(1'b1, OFS_MOTOR_MAX, 32'h320);
        settle(2);
        lim(10'h1f4, 10'h000);
        apb(1'b1, OFS_FWD_INT, 32'h384);
        apb(1'b0, OFS_FWD_INT, 32'h0);
        chk(rd, 32'h00000320);
        apb(1'b1, OFS_MOTOR_MAX, 32'h12c);
        apb(1'b1, OFS_FWD_INT, 32'hfa);
        apb(1'b1, OFS_REV_INT, 32'hfa);
        settle(2);
        lim(10'h0fa, 10'h0fa);
        $display("internal done");
    endtask
    task automatic t_external();
        apb(1'b1, OFS_FWD_EXT, 32'h64);
        apb(1'b1, OFS_REV_EXT, 32'h28);
        fwd_on <= 1'b1;
        settle(4);
        lim(10'h064, 10'h0fa);
        fwd_on <= 1'b0;
        rev_on <= 1'b1;
        settle(4);
        lim(10'h0fa, 10'h028);
        apb(1'b1, OFS_FWD_EXT, 32'h2bc);
        fwd_on <= 1'b1;
        rev_on <= 1'b0;
        settle(4);
        lim(10'h0fa, 10'h0fa);
        fwd_on <= 1'b0;
        $display("external done");
    endtask
    task automatic t_alloc();
        apb(1'b1, OFS_ALLOC, 32'h65);
        apb(1'b1, OFS_FWD_EXT, 32'h3c);
        fwd_term <= 3'h5;
        rev_term <= 3'h6;
        fwd_on <= 1'b1;
        rev_on <= 1'b1;
        settle(4);
        lim(10'h03c, 10'h028);
        fwd_on <= 1'b0;
        rev_on <= 1'b0;
        $display("alloc done");
    endtask
    task automatic t_analog();
        apb(1'b1, OFS_FSEL, 32'h1);
        apb(1'b0, OFS_FSEL, 32'h0);
        chk(rd, 32'h00000001);
        chk({31'h0, analog_mode}, 32'h0);
        analog_ref <= 16'hffec;
        fwd_term <= 3'h0;
        rev_term <= 3'h1;
        // the reset is the restart that activates the new mode
        do_reset();
        settle(1);
        chk({31'h0, analog_mode}, 32'h1);
        lim(10'h014, 10'h014);
        ctrl_mode <= CTRL_FORCE;
        settle(2);
        chk({31'h0, analog_mode}, 32'h0);
        lim(10'h01e, 10'h01e);
        ctrl_mode <= CTRL_POSITION;
        analog_ref <= 16'h0032;
        settle(2);
        lim(10'h01e, 10'h01e);
        chk({31'h0, analog_mode}, 32'h1);
        $display("analog done");
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        do_reset();
        t_defaults();
        t_internal();
        t_external();
        t_alloc();
        t_analog();
        end_sim();
    end
endmodule
`default_nettype wire
